// file: cpu_model.sv
// Purpose: CPU core bus and debugger side facing the break/trace block.
// Assumes: One access, fetch or branch per call, one cycle each.
// Notes: Idle address lines toggle so stale values never look valid.
`timescale 1ns/1ps
module cpu_model (
   input wire logic clk_in,
   input wire logic halt_req_in,
   input wire logic break_in,
   output logic fetch_valid_out,
   output logic [23:0] fetch_addr_out,
   output logic branch_valid_out,
   output logic [23:0] src_out,
   output logic [23:0] dst_out,
   output logic dbus_valid_out,
   output logic [23:0] dbus_addr_out,
   output logic [15:0] dbus_data_out,
   output logic write_out,
   output logic word_out,
   output logic run_start_out,
   output logic halted_out
);
   initial begin
      {fetch_valid_out, branch_valid_out, dbus_valid_out} = 3'h0;
      {fetch_addr_out, src_out, dst_out, dbus_addr_out} = 96'h0;
      {dbus_data_out, write_out, word_out, run_start_out} = 19'h0;
      halted_out = 1'b0;
   end
   // Debugger stops the core on any break and lets it go on run start
   // Plain always, since the initial block also gives this a start value
   always @(posedge clk_in) begin
      if (break_in || halt_req_in) halted_out <= 1'b1;
      else if (run_start_out) halted_out <= 1'b0;
   end
   task automatic fetch(input logic [23:0] a);
      @(posedge clk_in);
      fetch_valid_out <= 1'b1;
      fetch_addr_out <= a;
      @(posedge clk_in);
      fetch_valid_out <= 1'b0;
      fetch_addr_out <= ~a;
   endtask
   task automatic access(input logic [23:0] a, input logic [15:0] d,
                         input logic wr, input logic wd);
      @(posedge clk_in);
      {dbus_valid_out, dbus_addr_out, dbus_data_out} <= {1'b1, a, d};
      {write_out, word_out} <= {wr, wd};
      @(posedge clk_in);
      {dbus_valid_out, dbus_addr_out, dbus_data_out} <= {1'b0, ~a, ~d};
   endtask
   task automatic branch(input logic [23:0] s, input logic [23:0] d);
      @(posedge clk_in);
      {branch_valid_out, src_out, dst_out} <= {1'b1, s, d};
      @(posedge clk_in);
      {branch_valid_out, src_out, dst_out} <= {1'b0, ~s, ~d};
   endtask
   task automatic go();
      @(posedge clk_in);
      run_start_out <= 1'b1;
      @(posedge clk_in);
      run_start_out <= 1'b0;
   endtask
   // Step the stopped instruction once before running free
   task automatic resume(input logic [23:0] a);
      fetch(a);
      go();
   endtask
endmodule // cpu_model

// file: obe_params.svh
// Purpose: Offsets, field positions, reset values and sizes of the
//          on-chip break and event trace block.
// Assumes: Byte addresses on an 8-bit register port, 32-bit data.
// Notes:   Definitions only.
`ifndef OBE_PARAMS_SVH
`define OBE_PARAMS_SVH

`define OBE_OFF_CTRL     8'h00
`define OBE_OFF_EVA_ADDR 8'h04
`define OBE_OFF_EVA_CFG  8'h08
`define OBE_OFF_EVA_DATA 8'h0c
`define OBE_OFF_EVB_ADDR 8'h10
`define OBE_OFF_EVB_CFG  8'h14
`define OBE_OFF_COND     8'h18
`define OBE_OFF_AM_EN    8'h1c
`define OBE_OFF_AM_BASE  8'h20
`define OBE_OFF_STATUS   8'h40
`define OBE_OFF_TRC_IDX  8'h44
`define OBE_OFF_TRC_LO   8'h48
`define OBE_OFF_TRC_HI   8'h4c

// Control register bits
`define OBE_CTRL_EN_A     0
`define OBE_CTRL_EN_B     1
`define OBE_CTRL_EN_BRK   2
`define OBE_CTRL_EN_TRC   3
`define OBE_CTRL_MODE     4
`define OBE_CTRL_FULL_BRK 5
`define OBE_CTRL_REARM    6

// Event configuration fields
`define OBE_CFG_MBITS_LSB 0
`define OBE_CFG_SIZE_LSB  5
`define OBE_CFG_DIR_LSB   7

// Condition register fields
`define OBE_COND_BRK_LSB   0
`define OBE_COND_START_LSB 3
`define OBE_COND_STOP_LSB  6
`define OBE_COND_PICK      9

`define OBE_RST_WORD 32'h0000_0000
`define OBE_TRC_DEPTH 16
`define OBE_AM_POINTS 8

`endif

// file: obe_pkg.sv
// Purpose: Types shared by the on-chip break and event trace block.
// Assumes: Encodings follow the order of declaration.
// Notes:   SEL_SPECIAL means go for start, halt for stop, none for break.
package obe_pkg;
   typedef enum logic [2:0] {
      SEL_SPECIAL, SEL_A, SEL_A_OR_B, SEL_A_AND_B, SEL_B_THEN_A, SEL_FULL
   } sel_t;
   typedef enum logic [1:0] {SIZE_ANY, SIZE_BYTE, SIZE_WORD} size_t;
   typedef enum logic [1:0] {DIR_RW, DIR_READ, DIR_WRITE} dir_t;
   typedef enum logic {TK_BRANCH, TK_DATA} kind_t;
endpackage

// file: onchip_break_event_trace.sv
// Purpose: Address-match breakpoints, two data-access event comparators,
//          break combiner, trace-full break and a branch/data trace unit.
// Assumes: CPU strobes are synchronous one-cycle pulses on MCLK_IN.
// Notes:   Registers sit on a plain strobe port, read data one cycle later.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "obe_params.svh"

module onchip_break_event_trace import obe_pkg::*; #(
   parameter int DEPTH = `OBE_TRC_DEPTH,
   parameter int AM_NUM = `OBE_AM_POINTS
) (
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [31:0] REG_RDATA_OUT,
   input wire logic FETCH_VALID_IN,
   input wire logic [23:0] FETCH_ADDR_IN,
   input wire logic BRANCH_VALID_IN,
   input wire logic [23:0] BRANCH_SRC_IN,
   input wire logic [23:0] BRANCH_DST_IN,
   input wire logic DBUS_VALID_IN,
   input wire logic [23:0] DBUS_ADDR_IN,
   input wire logic [15:0] DBUS_DATA_IN,
   input wire logic DBUS_WRITE_IN,
   input wire logic DBUS_WORD_IN,
   input wire logic RUN_START_IN,
   input wire logic HALTED_IN,
   output logic HALT_REQ_OUT,
   output logic BREAK_OUT,
   output logic EVA_MATCH_OUT,
   output logic EVB_MATCH_OUT,
   output logic TRACE_ACTIVE_OUT,
   output logic TRACE_FULL_OUT
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int IW = $clog2(DEPTH);
   localparam int EW = 49;

   typedef struct packed {
      logic en_a;
      logic en_b;
      logic en_brk;
      logic en_trc;
      logic mode;
      logic full_brk;
      logic [23:0] eva_addr;
      logic [8:0] eva_cfg;
      logic [31:0] eva_data;
      logic [23:0] evb_addr;
      logic [8:0] evb_cfg;
      logic [9:0] cond;
      logic [AM_NUM-1:0] am_en;
      logic [AM_NUM-1:0][23:0] am_addr;
      logic [IW-1:0] idx;
      logic [31:0] rdata;
      logic [2:0] a_seen;
      logic [2:0] b_seen;
      logic active;
      logic full;
      logic [CW-1:0] cnt;
      logic ma;
      logic mb;
      logic brk;
      logic [DEPTH-1:0][EW-1:0] mem;
   } state_t;

   state_t q, d;

   function automatic logic addr_hit(input logic [23:0] acc,
                                     input logic [23:0] ref_a,
                                     input logic [8:0] cfg);
      logic [23:0] m;
      m = 24'hffffff << cfg[`OBE_CFG_MBITS_LSB +: 5];
      return ((acc ^ ref_a) & m) == 24'h000000;
   endfunction

   function automatic logic qual_hit(input logic [8:0] cfg,
                                     input logic wr, input logic word);
      size_t sz;
      dir_t dr;
      logic s_ok;
      logic d_ok;
      sz = size_t'(cfg[`OBE_CFG_SIZE_LSB +: 2]);
      dr = dir_t'(cfg[`OBE_CFG_DIR_LSB +: 2]);
      s_ok = (sz == SIZE_ANY) || (sz == SIZE_BYTE && !word) ||
             (sz == SIZE_WORD && word);
      d_ok = (dr == DIR_RW) || (dr == DIR_READ && !wr) ||
             (dr == DIR_WRITE && wr);
      return s_ok && d_ok;
   endfunction

   function automatic logic cond_fire(input sel_t s, input logic a,
                                      input logic b, input logic as,
                                      input logic bs);
      logic r;
      unique case (s)
         SEL_A: r = a;
         SEL_A_OR_B: r = a | b;
         SEL_A_AND_B: r = (a | as) & (b | bs);
         SEL_B_THEN_A: r = a & bs;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   logic [15:0] dmask;
   logic a_hit, b_hit, rearm, rec, pick;
   logic [2:0] fire;
   sel_t sel [3];
   logic [EW-1:0] entry;
   logic [AM_NUM-1:0] am_hit;

   // Halt request is combinational so the CPU stops before execution
   always_comb begin
      for (int i = 0; i < AM_NUM; i++) begin
         am_hit[i] = q.am_en[i] && FETCH_ADDR_IN == q.am_addr[i];
      end
   end
   assign HALT_REQ_OUT = FETCH_VALID_IN && (|am_hit);

   always_comb begin
      d = q;
      d.ma = 1'b0;
      d.mb = 1'b0;
      d.brk = 1'b0;
      d.rdata = 32'h0000_0000;
      rearm = REG_WR_IN && REG_ADDR_IN == `OBE_OFF_CTRL &&
              REG_WDATA_IN[`OBE_CTRL_REARM];
      // Byte accesses see only the low mask byte
      dmask = DBUS_WORD_IN ? q.eva_data[31:16] :
              {8'h00, q.eva_data[23:16]};
      a_hit = q.en_a && DBUS_VALID_IN &&
              addr_hit(DBUS_ADDR_IN, q.eva_addr, q.eva_cfg) &&
              qual_hit(q.eva_cfg, DBUS_WRITE_IN, DBUS_WORD_IN) &&
              ((DBUS_DATA_IN ^ q.eva_data[15:0]) & dmask) ==
              16'h0000;
      b_hit = q.en_b && DBUS_VALID_IN &&
              addr_hit(DBUS_ADDR_IN, q.evb_addr, q.evb_cfg) &&
              qual_hit(q.evb_cfg, DBUS_WRITE_IN, DBUS_WORD_IN);
      d.ma = a_hit;
      d.mb = b_hit;
      sel[0] = sel_t'(q.cond[`OBE_COND_BRK_LSB +: 3]);
      sel[1] = sel_t'(q.cond[`OBE_COND_START_LSB +: 3]);
      sel[2] = sel_t'(q.cond[`OBE_COND_STOP_LSB +: 3]);
      for (int i = 0; i < 3; i++) begin
         fire[i] = cond_fire(sel[i], a_hit, b_hit, q.a_seen[i],
                             q.b_seen[i]);
         if (fire[i]) begin
            d.a_seen[i] = 1'b0;
            d.b_seen[i] = 1'b0;
         end else if (rearm) begin
            // An access in the re-arm cycle still counts, so set wins
            d.a_seen[i] = a_hit;
            d.b_seen[i] = b_hit;
         end else begin
            d.a_seen[i] = q.a_seen[i] | a_hit;
            d.b_seen[i] = q.b_seen[i] | b_hit;
         end
      end
      d.brk = q.en_brk && fire[0];
      pick = q.cond[`OBE_COND_PICK] ? (a_hit | b_hit) : a_hit;
      // Mode is one bit, so the two trace kinds are exclusive
      if (q.mode == TK_DATA) begin
         rec = DBUS_VALID_IN && pick;
         entry = {TK_DATA, DBUS_ADDR_IN, 8'h00, DBUS_DATA_IN};
      end else begin
         rec = BRANCH_VALID_IN;
         entry = {TK_BRANCH, BRANCH_SRC_IN, BRANCH_DST_IN};
      end
      rec = rec && q.active && !q.full;
      if (rec) begin
         d.mem[q.cnt[IW-1:0]] = entry;
         d.cnt = q.cnt + CW'(1);
         if (q.cnt == CW'(DEPTH - 1)) begin
            d.full = 1'b1;
            d.brk = d.brk | (q.en_brk && q.full_brk);
         end
      end
      if (q.active && ((sel[2] == SEL_SPECIAL && HALTED_IN) ||
          (sel[2] == SEL_FULL && q.full) || fire[2])) begin
         d.active = 1'b0;
      end else if (!q.active && q.en_trc && !q.full &&
          ((sel[1] == SEL_SPECIAL && RUN_START_IN) || fire[1])) begin
         d.active = 1'b1;
      end
      if (REG_WR_IN) begin
         unique case (REG_ADDR_IN)
            `OBE_OFF_CTRL: begin
               d.en_a = REG_WDATA_IN[`OBE_CTRL_EN_A];
               d.en_b = REG_WDATA_IN[`OBE_CTRL_EN_B];
               d.en_brk = REG_WDATA_IN[`OBE_CTRL_EN_BRK];
               d.en_trc = REG_WDATA_IN[`OBE_CTRL_EN_TRC];
               d.mode = REG_WDATA_IN[`OBE_CTRL_MODE];
               d.full_brk = REG_WDATA_IN[`OBE_CTRL_FULL_BRK];
            end
            `OBE_OFF_EVA_ADDR: d.eva_addr = REG_WDATA_IN[23:0];
            `OBE_OFF_EVA_CFG: d.eva_cfg = REG_WDATA_IN[8:0];
            `OBE_OFF_EVA_DATA: d.eva_data = REG_WDATA_IN;
            `OBE_OFF_EVB_ADDR: d.evb_addr = REG_WDATA_IN[23:0];
            `OBE_OFF_EVB_CFG: d.evb_cfg = REG_WDATA_IN[8:0];
            `OBE_OFF_COND: d.cond = REG_WDATA_IN[9:0];
            `OBE_OFF_AM_EN: d.am_en = REG_WDATA_IN[AM_NUM-1:0];
            `OBE_OFF_TRC_IDX: d.idx = REG_WDATA_IN[IW-1:0];
            default: begin
               for (int i = 0; i < AM_NUM; i++) begin
                  if (REG_ADDR_IN == `OBE_OFF_AM_BASE + 8'(4 * i)) begin
                     d.am_addr[i] = REG_WDATA_IN[23:0];
                  end
               end
            end
         endcase
      end
      if (rearm) begin
         d.cnt = '0;
         d.full = 1'b0;
         d.active = 1'b0;
      end
      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            `OBE_OFF_CTRL: d.rdata = {26'h0, q.full_brk, q.mode, q.en_trc,
                                      q.en_brk, q.en_b, q.en_a};
            `OBE_OFF_EVA_ADDR: d.rdata = {8'h00, q.eva_addr};
            `OBE_OFF_EVA_CFG: d.rdata = {23'h0, q.eva_cfg};
            `OBE_OFF_EVA_DATA: d.rdata = q.eva_data;
            `OBE_OFF_EVB_ADDR: d.rdata = {8'h00, q.evb_addr};
            `OBE_OFF_EVB_CFG: d.rdata = {23'h0, q.evb_cfg};
            `OBE_OFF_COND: d.rdata = {22'h0, q.cond};
            `OBE_OFF_AM_EN: d.rdata = 32'(q.am_en);
            `OBE_OFF_STATUS: d.rdata = {16'h0, 8'(q.cnt), 4'h0,
                                        q.a_seen[0], q.b_seen[0],
                                        q.full, q.active};
            `OBE_OFF_TRC_IDX: d.rdata = 32'(q.idx);
            `OBE_OFF_TRC_LO: d.rdata = q.mem[q.idx][31:0];
            `OBE_OFF_TRC_HI: d.rdata = {15'h0, q.mem[q.idx][EW-1:32]};
            default: begin
               for (int i = 0; i < AM_NUM; i++) begin
                  if (REG_ADDR_IN == `OBE_OFF_AM_BASE + 8'(4 * i)) begin
                     d.rdata = {8'h00, q.am_addr[i]};
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign REG_RDATA_OUT = q.rdata;
   assign BREAK_OUT = q.brk;
   assign EVA_MATCH_OUT = q.ma;
   assign EVB_MATCH_OUT = q.mb;
   assign TRACE_ACTIVE_OUT = q.active;
   assign TRACE_FULL_OUT = q.full;

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   AST_AM_HALT: assert property (
      FETCH_VALID_IN && q.am_en[0] && FETCH_ADDR_IN == q.am_addr[0]
      |-> HALT_REQ_OUT)
      else $error("breakpoint fetch without halt request");
   AST_A_PULSE: assert property (
      EVA_MATCH_OUT |-> $past(DBUS_VALID_IN) && $past(q.en_a))
      else $error("event A pulse without enabled access");
   AST_A_DISABLED: assert property (
      !q.en_a && !q.en_b |=> !EVA_MATCH_OUT && !EVB_MATCH_OUT)
      else $error("disabled event matched");
   AST_SIZE: assert property (
      DBUS_VALID_IN && q.eva_cfg[`OBE_CFG_SIZE_LSB +: 2] ==
      (DBUS_WORD_IN ? SIZE_BYTE : SIZE_WORD) |=> !EVA_MATCH_OUT)
      else $error("access of other size matched event A");
   AST_DIR: assert property (
      DBUS_VALID_IN && DBUS_WRITE_IN &&
      q.evb_cfg[`OBE_CFG_DIR_LSB +: 2] == DIR_READ |=> !EVB_MATCH_OUT)
      else $error("write matched read-only event B");
   AST_BRK_A: assert property (
      q.en_brk && q.cond[2:0] == SEL_A && d.ma |=> BREAK_OUT)
      else $error("event A break missing");
   AST_SEQ_CLEAR: assert property (
      q.en_brk && q.cond[2:0] == SEL_B_THEN_A && fire[0]
      |=> !q.b_seen[0])
      else $error("sequence latch not cleared on fire");
   AST_BRANCH_REC: assert property (
      q.active && !q.full && q.mode == TK_BRANCH && BRANCH_VALID_IN
      && !rearm |=> q.cnt == $past(q.cnt) + CW'(1))
      else $error("branch not recorded");
   AST_DATA_PICK: assert property (
      q.mode == TK_DATA && !pick && !rearm |=> $stable(q.cnt))
      else $error("data recorded without pick-up event");
   AST_FULL_BRK: assert property (
      q.en_brk && q.full_brk && $rose(q.full) |-> BREAK_OUT)
      else $error("trace full did not break");
   AST_B_PULSE: assert property (
      EVB_MATCH_OUT |-> $past(DBUS_VALID_IN) && $past(q.en_b))
      else $error("event B pulse without enabled access");
   AST_HALT_ONLY: assert property (
      !FETCH_VALID_IN |-> !HALT_REQ_OUT)
      else $error("halt request without fetch");
   AST_FULL_HOLD: assert property (
      q.full && !rearm |=> $stable(q.cnt))
      else $error("entry recorded into full buffer");
   AST_START: assert property (
      !q.active && q.en_trc && !q.full && fire[1] && !rearm
      |=> TRACE_ACTIVE_OUT)
      else $error("trace did not start on event");
   AST_STOP_HALT: assert property (
      q.active && q.cond[`OBE_COND_STOP_LSB +: 3] == SEL_SPECIAL &&
      HALTED_IN |=> !TRACE_ACTIVE_OUT)
      else $error("trace did not stop on halt");
   AST_MODE_EXCL: assert property (
      q.mode == TK_BRANCH && !BRANCH_VALID_IN && !rearm
      |=> $stable(q.cnt))
      else $error("branch mode recorded a non-branch");
   AST_NO_DATA_MASK: assert property (
      q.en_a && DBUS_VALID_IN && q.eva_data[31:16] == 16'h0000 &&
      addr_hit(DBUS_ADDR_IN, q.eva_addr, q.eva_cfg) &&
      qual_hit(q.eva_cfg, DBUS_WRITE_IN, DBUS_WORD_IN) |=> EVA_MATCH_OUT)
      else $error("zero data mask blocked event A");

endmodule // onchip_break_event_trace

// file: onchip_break_event_trace_test.sv
// Purpose: Self-checking bench for the on-chip break and event trace block.
// Assumes: Trace depth shrunk to 4 so a full buffer is reached quickly.
// Notes: Register port driven here, CPU side by the partner model.
`timescale 1ns/1ps
module onchip_break_event_trace_test;
   import obe_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic fv, bv, dv, dw, dwd, go, hlt, halt_req, brk, eva, evb, act, full;
   logic [23:0] fa, bs, bd, da;
   logic [15:0] dd;
   int n_mismatch = 0;
   int checks = 0;
   initial forever #2.5 clk = ~clk;
   onchip_break_event_trace #(.DEPTH(4)) i_onchip_break_event_trace (
      .MCLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata), .FETCH_VALID_IN(fv), .FETCH_ADDR_IN(fa),
      .BRANCH_VALID_IN(bv), .BRANCH_SRC_IN(bs), .BRANCH_DST_IN(bd),
      .DBUS_VALID_IN(dv), .DBUS_ADDR_IN(da), .DBUS_DATA_IN(dd),
      .DBUS_WRITE_IN(dw), .DBUS_WORD_IN(dwd), .RUN_START_IN(go),
      .HALTED_IN(hlt), .HALT_REQ_OUT(halt_req), .BREAK_OUT(brk),
      .EVA_MATCH_OUT(eva), .EVB_MATCH_OUT(evb),
      .TRACE_ACTIVE_OUT(act), .TRACE_FULL_OUT(full));
   cpu_model i_cpu_model (
      .clk_in(clk), .halt_req_in(halt_req), .break_in(brk),
      .fetch_valid_out(fv), .fetch_addr_out(fa), .branch_valid_out(bv),
      .src_out(bs), .dst_out(bd), .dbus_valid_out(dv),
      .dbus_addr_out(da), .dbus_data_out(dd), .write_out(dw),
      .word_out(dwd), .run_start_out(go), .halted_out(hlt));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      {rd, addr} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Access then look at match and break pulses one cycle later
   task automatic acc(input logic [23:0] a, input logic [15:0] d,
                      input logic w, input logic wd, input logic [2:0] e);
      i_cpu_model.access(a, d, w, wd);
      #1 chk({eva, evb, brk}, e);
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #50000;
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rreg(8'h40, 32'h0);
      rreg(8'h3c, 32'h0);
      wreg(8'h20, 32'h001234);
      // Halt request needs an enabled point and a fetch of its exact address
      fork
         i_cpu_model.fetch(24'h001234);
         #6 chk(halt_req, 1'b0);
      join
      wreg(8'h1c, 32'h1);
      fork
         i_cpu_model.fetch(24'h001235);
         #6 chk(halt_req, 1'b0);
      join
      fork
         i_cpu_model.resume(24'h001234);
         #6 chk(halt_req, 1'b1);
      join
      #1 chk(act, 1'b0);
      // Event A on word writes of 0x420 only, event B on byte reads of 0x400-0x403
      wreg(8'h04, 32'h000420);
      wreg(8'h08, 32'h140);
      wreg(8'h0c, 32'h00ff_0012);
      wreg(8'h10, 32'h000400);
      wreg(8'h14, 32'h0a2);
      wreg(8'h18, {22'h0, 1'b0, SEL_SPECIAL, SEL_SPECIAL, SEL_A});
      wreg(8'h00, 32'h7);
      acc(24'h000420, 16'h3412, 1'b1, 1'b1, 3'b101);
      acc(24'h000420, 16'h3413, 1'b1, 1'b1, 3'b000);
      acc(24'h000420, 16'h3412, 1'b0, 1'b1, 3'b000);
      acc(24'h000420, 16'h3412, 1'b1, 1'b0, 3'b000);
      acc(24'h000403, 16'h0000, 1'b0, 1'b0, 3'b010);
      acc(24'h000404, 16'h0000, 1'b0, 1'b0, 3'b000);
      acc(24'h000403, 16'h0000, 1'b1, 1'b0, 3'b000);
      wreg(8'h0c, 32'h0000_0012);
      acc(24'h000420, 16'h9999, 1'b1, 1'b1, 3'b101);
      wreg(8'h00, 32'h6);
      acc(24'h000420, 16'h0012, 1'b1, 1'b1, 3'b000);
      wreg(8'h00, 32'h47);
      wreg(8'h18, {22'h0, 1'b0, SEL_SPECIAL, SEL_SPECIAL, SEL_B_THEN_A});
      acc(24'h000420, 16'h0012, 1'b1, 1'b1, 3'b100);
      acc(24'h000401, 16'h0000, 1'b0, 1'b0, 3'b010);
      acc(24'h000420, 16'h0012, 1'b1, 1'b1, 3'b101);
      acc(24'h000420, 16'h0012, 1'b1, 1'b1, 3'b100);
      // Branch trace from go until the buffer fills
      wreg(8'h18, {22'h0, 1'b0, SEL_FULL, SEL_SPECIAL, SEL_SPECIAL});
      wreg(8'h00, 32'h6c);
      i_cpu_model.go();
      #1 chk({act, full}, 2'b10);
      for (int i = 0; i < 4; i++) begin
         i_cpu_model.branch(24'h0083c4 + 24'(i), 24'h00e096 + 24'(i));
      end
      #1 chk({full, brk}, 2'b11);
      rreg(8'h40, 32'h0000_0402);
      wreg(8'h44, 32'h0);
      rreg(8'h48, 32'hc400_e096);
      rreg(8'h4c, 32'h0000_0083);
      // Data trace keeps only accesses that hit event A
      wreg(8'h00, 32'h59);
      i_cpu_model.go();
      acc(24'h000420, 16'h3412, 1'b1, 1'b1, 3'b100);
      acc(24'h000422, 16'h3412, 1'b1, 1'b1, 3'b000);
      rreg(8'h40, 32'h0000_0109);
      wreg(8'h44, 32'h0);
      rreg(8'h48, 32'h2000_3412);
      rreg(8'h4c, 32'h0001_0004);
      // A and B together break, A starts the trace, the halt stops it
      wreg(8'h18, {22'h0, 1'b1, SEL_SPECIAL, SEL_A, SEL_A_AND_B});
      wreg(8'h00, 32'h5f);
      acc(24'h000401, 16'h0000, 1'b0, 1'b0, 3'b010);
      acc(24'h000420, 16'h0055, 1'b1, 1'b1, 3'b101);
      acc(24'h000402, 16'h0000, 1'b0, 1'b0, 3'b010);
      rreg(8'h40, 32'h0000_0104);
      rreg(8'h48, 32'h0200_0000);
      summarize();
   end
endmodule // onchip_break_event_trace_test
